//--- hw/rfs_reg_bank.sv
`timescale 1ns/1ps
// How it works
// - Hardwired reserved-zero bits read zero and drop every write.
// - Writable reserved-zero bits keep what a direct write puts there.
// - Stored reserved-zero values only come back on reads, never steer.
// - Each field's hardwired or stored form is a fixed parameter.
// - Indirect write clears context-reserved bits while they are reserved.
// - Context-reserved bits read back their stored value, any context.
// - Unwritten reserved storage reads its reset value.
// - Reserved bits of read-only registers read zero.
// - Write-zero and write-one fields ignore all writes; preserve fields take direct writes.
// - Unknown preserve-one fields read all ones, ignore writes.
// - Unknown preserve-zero fields read all zeros, ignore writes.
// - Unknown-valued fields read as zeros.
// - Unspecified reads return constants, never hidden state.
module rfs_reg_bank #(
   parameter int N_REGS = rfs_pkg::RFS_NREGS,
   parameter logic [N_REGS*rfs_pkg::RFS_DW-1:0] P_STORE =
      {N_REGS{rfs_pkg::RFS_STORE_DEF}},
   parameter logic [N_REGS*rfs_pkg::RFS_DW-1:0] P_RSV =
      {N_REGS{rfs_pkg::RFS_RSV_DEF}},
   parameter logic [N_REGS*rfs_pkg::RFS_DW-1:0] P_CTX =
      {N_REGS{rfs_pkg::RFS_CTX_DEF}},
   parameter logic [N_REGS*rfs_pkg::RFS_DW-1:0] P_ONE =
      {N_REGS{rfs_pkg::RFS_ONE_DEF}},
   parameter logic [N_REGS*rfs_pkg::RFS_DW-1:0] P_RO =
      {N_REGS{rfs_pkg::RFS_RO_DEF}},
   parameter logic [N_REGS*rfs_pkg::RFS_DW-1:0] P_RESET =
      {N_REGS{rfs_pkg::RFS_RESET_DEF}},
   parameter logic [N_REGS-1:0] P_RO_REGS = rfs_pkg::RFS_RO_REGS_DEF
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire rfs_pkg::rfs_req_s req_i,
   input wire logic [N_REGS-1:0] ctx_rsv_i,
   input wire logic [N_REGS*rfs_pkg::RFS_DW-1:0] status_i,
   output rfs_pkg::rfs_rsp_s rsp_o,
   output logic [N_REGS*rfs_pkg::RFS_DW-1:0] oper_o
);
   localparam int DW = rfs_pkg::RFS_DW;
   localparam int AW = rfs_pkg::RFS_AW;
   localparam logic [N_REGS*DW-1:0] KEEP_ALL = P_STORE | P_RSV | P_CTX;

   logic [DW-1:0] store_q [N_REGS];
   logic [DW-1:0] store_d [N_REGS];
   logic [DW-1:0] rd_val [N_REGS];
   logic [N_REGS*DW-1:0] store_flat;
   logic [N_REGS*DW-1:0] ctx_rsv_m;
   logic hit;
   logic [AW-1:0] rd_addr_q;
   logic [AW-1:0] rd_addr_d;
   rfs_pkg::rfs_rsp_s rsp_q;
   rfs_pkg::rfs_rsp_s rsp_d;

   function automatic logic [DW-1:0] mask_of(
      input logic [N_REGS*DW-1:0] m,
      input logic [AW-1:0] idx
   );
      logic [DW-1:0] r;
      r = '0;
      if (int'(idx) < N_REGS) begin
         r = m[int'(idx)*DW +: DW];
      end
      return r;
   endfunction

   // Out-of-range addresses hit nothing
   assign hit = req_i.valid && (int'(req_i.addr) < N_REGS);

   generate
      for (genvar g = 0; g < N_REGS; g++) begin : g_reg
         rfs_field_policy #(
            .DW(DW),
            .STORE_M(P_STORE[g*DW +: DW]),
            .RSV_M(P_RSV[g*DW +: DW]),
            .CTX_M(P_CTX[g*DW +: DW]),
            .ONE_M(P_ONE[g*DW +: DW]),
            .RO_M(P_RO[g*DW +: DW]),
            .RO_REG(P_RO_REGS[g])
         ) u_policy (
            .store_q_i(store_q[g]),
            .hit_i(hit && (int'(req_i.addr) == g)),
            .kind_i(req_i.kind),
            .wdata_i(req_i.wdata),
            .ctx_rsv_i(ctx_rsv_i[g]),
            .status_i(status_i[g*DW +: DW]),
            .store_d_o(store_d[g]),
            .rd_val_o(rd_val[g]),
            .oper_o(oper_o[g*DW +: DW])
         );
         assign store_flat[g*DW +: DW] = store_q[g];
         assign ctx_rsv_m[g*DW +: DW] = {DW{ctx_rsv_i[g]}};
      end
   endgenerate

   always_ff @(posedge clk_i) begin
      for (int i = 0; i < N_REGS; i++) begin
         if (!rst_n_i) begin
            store_q[i] <= P_RESET[i*DW +: DW] & KEEP_ALL[i*DW +: DW];
         end else begin
            store_q[i] <= store_d[i];
         end
      end
   end

   always_comb begin
      rsp_d = '0;
      rd_addr_d = rd_addr_q;
      if (req_i.valid && req_i.kind == rfs_pkg::RFS_ACC_READ) begin
         rsp_d.valid = 1'b1;
         rsp_d.hit = hit;
         rd_addr_d = req_i.addr;
         if (hit) begin
            rsp_d.data = rd_val[int'(req_i.addr)];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rsp_q <= '0;
         rd_addr_q <= rfs_pkg::RFS_ADDR_RST;
      end else begin
         rsp_q <= rsp_d;
         rd_addr_q <= rd_addr_d;
      end
   end

   assign rsp_o = rsp_q;

   // Checks
   logic rd_req;
   logic dwr_hit;
   logic iwr_hit;
   logic ro_tgt;
   assign rd_req = req_i.valid && req_i.kind == rfs_pkg::RFS_ACC_READ;
   assign dwr_hit = hit && req_i.kind == rfs_pkg::RFS_ACC_DIRECT;
   assign iwr_hit = hit && req_i.kind == rfs_pkg::RFS_ACC_INDIRECT;
   assign ro_tgt = P_RO_REGS[req_i.addr];

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   hw_zero_read_a: assert property (
      rsp_q.valid && rsp_q.hit && !P_RO_REGS[rd_addr_q] |->
      (rsp_q.data & ~(mask_of(KEEP_ALL, rd_addr_q) |
      mask_of(P_ONE, rd_addr_q))) == '0)
      else $error("hardwired zero bit read nonzero");

   direct_write_store_a: assert property (
      dwr_hit && !ro_tgt |=>
      (store_flat & (KEEP_ALL & (mask_of(KEEP_ALL, $past(req_i.addr))
      << (int'($past(req_i.addr)) * DW)))) ==
      (({{(N_REGS-1)*DW{1'b0}}, $past(req_i.wdata)}
      << (int'($past(req_i.addr)) * DW)) & KEEP_ALL &
      (mask_of(KEEP_ALL, $past(req_i.addr))
      << (int'($past(req_i.addr)) * DW))))
      else $error("direct write did not reach storage");

   reserved_no_effect_a: assert property (
      (oper_o & P_RSV) == '0)
      else $error("reserved storage leaks to operation");

   fixed_class_a: assert property (
      (store_flat & ~KEEP_ALL) == '0)
      else $error("unimplemented bit holds state");

   indirect_clear_a: assert property (
      iwr_hit && !ro_tgt && ctx_rsv_i[req_i.addr] |=>
      (store_q[$past(req_i.addr)] &
      (mask_of(P_CTX, $past(req_i.addr)) |
      mask_of(P_RSV, $past(req_i.addr)))) == '0)
      else $error("indirect write left reserved bit set");

   ctx_readback_a: assert property (
      rd_req && hit && !ro_tgt |=>
      (rsp_q.data & mask_of(P_CTX, rd_addr_q)) ==
      ($past(store_q[req_i.addr]) & mask_of(P_CTX, rd_addr_q)))
      else $error("context field readback mismatch");

   reset_value_a: assert property (
      $past(!rst_n_i) |-> store_flat == (P_RESET & KEEP_ALL))
      else $error("storage not at reset value");

   ro_reserved_a: assert property (
      rsp_q.valid && rsp_q.hit && P_RO_REGS[rd_addr_q] |->
      (rsp_q.data & ~(mask_of(P_RO, rd_addr_q) |
      mask_of(P_ONE, rd_addr_q))) == '0)
      else $error("read-only reserved bit nonzero");

   ignored_write_a: assert property (
      req_i.valid && req_i.kind != rfs_pkg::RFS_ACC_READ |=>
      $stable(store_flat & ~KEEP_ALL))
      else $error("ignored field changed on write");

   reads_one_a: assert property (
      rsp_q.valid && rsp_q.hit |->
      (rsp_q.data & mask_of(P_ONE, rd_addr_q)) ==
      mask_of(P_ONE, rd_addr_q))
      else $error("read-one field not all ones");

   reads_zero_a: assert property (
      rsp_q.valid && rsp_q.hit && !P_RO_REGS[rd_addr_q] |->
      (rsp_q.data & ~mask_of(KEEP_ALL | P_ONE, rd_addr_q)) == '0)
      else $error("preserve-zero field not zero");

   unknown_zero_a: assert property (
      rsp_q.valid && !rsp_q.hit |-> rsp_q.data == '0)
      else $error("unknown field read nonzero");

   unmapped_quiet_a: assert property (
      rd_req && !hit |=> rsp_q.valid && rsp_q.data == '0 ##1
      !rsp_q.valid || rsp_q.hit || rsp_q.data == '0)
      else $error("unmapped read exposed data");

   read_timing_a: assert property (
      rd_req |=> rsp_q.valid ##0 ($past(rd_req, 1) && !rsp_q.hit ||
      rsp_q.data == $past(rd_val[req_i.addr])) or !rsp_q.hit)
      else $error("read answer late or wrong");

   // Answer is a one-cycle pulse, never spontaneous
   read_pulse_a: assert property (
      !rd_req |=> !rsp_q.valid)
      else $error("read answer without request");

   // Writes to read-only registers leave all storage unchanged
   ro_write_drop_a: assert property (
      hit && req_i.kind != rfs_pkg::RFS_ACC_READ && ro_tgt |=>
      $stable(store_flat))
      else $error("write to read-only register changed storage");

   // Context bits must not steer while reserved
   ctx_oper_gate_a: assert property (
      (oper_o & P_CTX & ctx_rsv_m) == '0)
      else $error("reserved context bit reached operation");

   oper_source_a: assert property (
      (oper_o & ~(P_STORE | P_CTX)) == '0)
      else $error("operation view holds non-operational bit");

   // Indirect write still lands in normal bits
   indirect_normal_a: assert property (
      iwr_hit && !ro_tgt |=>
      (store_q[$past(req_i.addr)] & mask_of(P_STORE, $past(req_i.addr))) ==
      ($past(req_i.wdata) & mask_of(P_STORE, $past(req_i.addr))))
      else $error("indirect write lost normal bits");

   cov_direct_then_read: cover property (
      dwr_hit ##1 rd_req && hit ##1 rsp_q.valid);
   cov_indirect_reserved: cover property (
      iwr_hit && ctx_rsv_i[req_i.addr]);
   cov_ro_read: cover property (rd_req && hit && ro_tgt);
   cov_unmapped: cover property (rd_req && !hit);
   cov_indirect_open: cover property (
      iwr_hit && !ctx_rsv_i[req_i.addr]);

endmodule

//--- hw/rfs_pkg.sv
package rfs_pkg;

   // Register geometry
   localparam int RFS_DW = 32;
   localparam int RFS_AW = 3;
   localparam int RFS_NREGS = 8;

   // Per-bit field classes of one register (default layout)
   localparam logic [RFS_DW-1:0] RFS_STORE_DEF = 32'h0000_ff00;
   localparam logic [RFS_DW-1:0] RFS_RSV_DEF = 32'h00ff_0000;
   localparam logic [RFS_DW-1:0] RFS_CTX_DEF = 32'h0f00_0000;
   localparam logic [RFS_DW-1:0] RFS_ONE_DEF = 32'h3000_0000;
   localparam logic [RFS_DW-1:0] RFS_RO_DEF = 32'h0000_00ff;
   localparam logic [RFS_DW-1:0] RFS_RESET_DEF = 32'h0000_0000;
   localparam logic [RFS_NREGS-1:0] RFS_RO_REGS_DEF = 8'h80;

   // Value after reset of the read port
   localparam logic [RFS_DW-1:0] RFS_RDATA_RST = 32'h0000_0000;
   localparam logic [RFS_AW-1:0] RFS_ADDR_RST = 3'h0;

   typedef enum logic [1:0] {
      RFS_ACC_READ = 2'b00,
      RFS_ACC_DIRECT = 2'b01,
      RFS_ACC_INDIRECT = 2'b10,
      RFS_ACC_NONE = 2'b11
   } rfs_acc_e;

   typedef struct packed {
      logic valid;
      rfs_acc_e kind;
      logic [RFS_AW-1:0] addr;
      logic [RFS_DW-1:0] wdata;
   } rfs_req_s;

   typedef struct packed {
      logic valid;
      logic hit;
      logic [RFS_DW-1:0] data;
   } rfs_rsp_s;

endpackage

//--- hw/rfs_field_policy.sv
`timescale 1ns/1ps
module rfs_field_policy #(
   parameter int DW = rfs_pkg::RFS_DW,
   parameter logic [DW-1:0] STORE_M = '0,
   parameter logic [DW-1:0] RSV_M = '0,
   parameter logic [DW-1:0] CTX_M = '0,
   parameter logic [DW-1:0] ONE_M = '0,
   parameter logic [DW-1:0] RO_M = '0,
   parameter bit RO_REG = 1'b0
) (
   input wire logic [DW-1:0] store_q_i,
   input wire logic hit_i,
   input wire rfs_pkg::rfs_acc_e kind_i,
   input wire logic [DW-1:0] wdata_i,
   input wire logic ctx_rsv_i,
   input wire logic [DW-1:0] status_i,
   output logic [DW-1:0] store_d_o,
   output logic [DW-1:0] rd_val_o,
   output logic [DW-1:0] oper_o
);
   localparam logic [DW-1:0] KEEP_M = STORE_M | RSV_M | CTX_M;

   always_comb begin
      store_d_o = store_q_i & KEEP_M;
      if (hit_i && !RO_REG) begin
         if (kind_i == rfs_pkg::RFS_ACC_DIRECT) begin
            store_d_o = wdata_i & KEEP_M;
         end else if (kind_i == rfs_pkg::RFS_ACC_INDIRECT) begin
            store_d_o = wdata_i & STORE_M;
            if (!ctx_rsv_i) begin
               store_d_o = store_d_o | (wdata_i & CTX_M);
            end
         end
      end
   end

   always_comb begin
      if (RO_REG) begin
         rd_val_o = (status_i & RO_M) | ONE_M;
      end else begin
         rd_val_o = (store_q_i & KEEP_M) | ONE_M;
      end
   end

   always_comb begin
      if (RO_REG) begin
         oper_o = '0;
      end else if (ctx_rsv_i) begin
         oper_o = store_q_i & STORE_M;
      end else begin
         oper_o = store_q_i & (STORE_M | CTX_M);
      end
   end

endmodule

//--- verif/rfs_sw_master.sv
`timescale 1ns/1ps
module rfs_sw_master (
   input wire logic clk_i,
   input wire rfs_pkg::rfs_rsp_s rsp_i,
   output rfs_pkg::rfs_req_s req_o
);
   // Last value read per register, for preserve-on-write
   logic [31:0] seen_q [8];
   logic [7:0] was_read_q;

   initial begin
      req_o = '{1'b0, rfs_pkg::RFS_ACC_NONE, 3'h0, 32'h0};
      was_read_q = 8'h00;
   end

   task automatic rd(input logic [2:0] a, output logic [31:0] d,
                     output logic v, output logic h);
      @(posedge clk_i);
      req_o <= '{1'b1, rfs_pkg::RFS_ACC_READ, a, 32'h0};
      @(posedge clk_i);
      req_o <= '{1'b0, rfs_pkg::RFS_ACC_NONE, 3'h0, 32'h0};
      // Answer stands one cycle only
      #1;
      d = rsp_i.data;
      v = rsp_i.valid;
      h = rsp_i.hit;
      seen_q[a] = rsp_i.data;
      was_read_q[a] = 1'b1;
   endtask

   // Raw writes break the write policies on purpose
   task automatic wr(input logic [2:0] a, input rfs_pkg::rfs_acc_e k,
                     input logic [31:0] val, input bit raw);
      logic [31:0] w;
      w = val;
      if (!raw) begin
         w[23:16] = was_read_q[a] ? seen_q[a][23:16] : 8'h00;
         w[31:30] = 2'b00;
         w[7:0] = 8'h00;
         w[29:28] = 2'b11;
      end
      @(posedge clk_i);
      req_o <= '{1'b1, k, a, w};
      @(posedge clk_i);
      req_o <= '{1'b0, rfs_pkg::RFS_ACC_NONE, 3'h0, 32'h0};
   endtask
endmodule

//--- verif/tb.sv
`timescale 1ns/1ps
module tb;
   localparam logic [31:0] STAT = 32'h5aa5_c33c;
   localparam logic [31:0] M = 32'hffff_ff00;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   rfs_pkg::rfs_req_s req;
   rfs_pkg::rfs_rsp_s rsp;
   logic [7:0] ctx_rsv = 8'h00;
   logic [255:0] status = {8{STAT}};
   logic [255:0] oper;
   int err_count = 0;
   int n_tests = 0;
   int cycles = 0;

   always #10 clk_i = ~clk_i;

   rfs_reg_bank DUT (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .req_i(req),
      .ctx_rsv_i(ctx_rsv),
      .status_i(status),
      .rsp_o(rsp),
      .oper_o(oper)
   );

   rfs_sw_master u_sw (
      .clk_i(clk_i),
      .rsp_i(rsp),
      .req_o(req)
   );

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic rd_chk(input logic [2:0] a, input logic [31:0] m,
                         input logic [31:0] e);
      logic [31:0] d;
      logic v;
      logic h;
      u_sw.rd(a, d, v, h);
      chk("rsp valid", 32'h1, {31'h0, v});
      chk("rsp hit", 32'h1, {31'h0, h});
      chk("read data", e & m, d & m);
   endtask

   task automatic set_ctx(input logic [7:0] c);
      @(posedge clk_i);
      ctx_rsv <= c;
      #1;
   endtask

   task automatic s_reset_vals();
      for (int r = 0; r < 7; r++) begin
         rd_chk(r[2:0], M, 32'h3000_0000);
      end
   endtask

   task automatic s_direct();
      for (int r = 0; r < 7; r++) begin
         u_sw.wr(r[2:0], rfs_pkg::RFS_ACC_DIRECT, 32'hffff_ffff, 1'b1);
         rd_chk(r[2:0], M, 32'h3fff_ff00);
      end
      set_ctx(8'h00);
      chk("oper open", 32'h0f00_ff00, oper[31:0] & 32'h0fff_ff00);
      set_ctx(8'hff);
      chk("oper rsv", 32'h0000_ff00, oper[31:0] & 32'h0fff_ff00);
   endtask

   task automatic s_context();
      u_sw.wr(3'h2, rfs_pkg::RFS_ACC_INDIRECT, 32'hffff_ffff, 1'b1);
      rd_chk(3'h2, M, 32'h3000_ff00);
      set_ctx(8'h00);
      u_sw.wr(3'h2, rfs_pkg::RFS_ACC_INDIRECT, 32'hffff_ffff, 1'b1);
      rd_chk(3'h2, M, 32'h3f00_ff00);
      set_ctx(8'hff);
      u_sw.wr(3'h2, rfs_pkg::RFS_ACC_DIRECT, 32'hffff_ffff, 1'b1);
      set_ctx(8'h00);
      rd_chk(3'h2, M, 32'h3fff_ff00);
      // Policy write keeps the reserved bits it just read
      u_sw.wr(3'h2, rfs_pkg::RFS_ACC_DIRECT, 32'h1234_5678, 1'b0);
      rd_chk(3'h2, M, 32'h32ff_5600);
   endtask

   task automatic s_read_only();
      rd_chk(3'h7, 32'h00ff_00ff, STAT & 32'h0000_00ff);
      u_sw.wr(3'h7, rfs_pkg::RFS_ACC_DIRECT, 32'hffff_ffff, 1'b1);
      @(posedge clk_i);
      status[255:224] <= 32'h0000_0081;
      rd_chk(3'h7, 32'h00ff_00ff, 32'h0000_0081);
   endtask

   task automatic s_rereset();
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rd_chk(3'h0, M, 32'h3000_0000);
   endtask

   // Whole run needs well under a thousand cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         end_sim();
      end
   end

   initial begin
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'b1;
      s_reset_vals();
      s_direct();
      s_context();
      s_read_only();
      s_rereset();
      end_sim();
   end
endmodule
